// file: sgr_cfg.svh
// Constants for the stepped gain ramp control block.
`ifndef SGR_CFG_SVH
`define SGR_CFG_SVH

// ----------------------------------------------------------------------------
// Register map, byte addresses
// ----------------------------------------------------------------------------
`define SGR_ADDR_W        12
`define SGR_ADDR_CTRL     12'h000
`define SGR_ADDR_STATUS   12'h004
`define SGR_ADDR_TARGET   12'h008
`define SGR_ADDR_PINS     12'h00C

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define SGR_CTRL_HOLD_BIT 0
`define SGR_CTRL_RESET    32'h0000_0000
`define SGR_STAT_STEP_LSB 0
`define SGR_STAT_LINE_LSB 8
`define SGR_STAT_MUTE_BIT 16
`define SGR_STAT_FSM_LSB  20
`define SGR_TGT_SPK_LSB   0
`define SGR_TGT_LINE_LSB  8
`define SGR_PIN_MODE_BIT  0
`define SGR_PIN_FADE_BIT  1
`define SGR_PIN_SDN_BIT   2

// ----------------------------------------------------------------------------
// Steps and timing
// ----------------------------------------------------------------------------
`define SGR_STEP_W        5
`define SGR_STEP_MIN      5'h00
`define SGR_STEP_MAX      5'h1F
`define SGR_CLK_HZ        200_000_000
`define SGR_TICK_HZ       60
`define SGR_TICK_CYCLES   (`SGR_CLK_HZ / `SGR_TICK_HZ)
`define SGR_TICKS_PER_STEP 4
`define SGR_FAST_MS       1

`endif

// file: sgr_pkg.sv
// Types shared by the stepped gain ramp control block.
package sgr_pkg;
	typedef logic [4:0] sgr_step_t;
	typedef enum logic [1:0] {
		ST_OFF,
		ST_ACTIVE,
		ST_FADE_OUT
	} sgr_state_t;
endpackage : sgr_pkg

// file: sgr_tick.sv
// Slow pacing tick generator and step-interval divider.
`timescale 1ns/1ps
`include "sgr_cfg.svh"
module sgr_tick #(
	parameter int TICK_CYCLES    = `SGR_TICK_CYCLES,
	parameter int TICKS_PER_STEP = `SGR_TICKS_PER_STEP
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	output logic      tick,
	output logic      step_due
);
	logic [31:0] div;
	logic [7:0]  tcnt;

	// --------------------------------------------------------------------
	// Internal slow clock, one pulse per period
	// --------------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div  <= 32'h0000_0000;
			tick <= 1'b0;
		end else if (div == 32'(TICK_CYCLES - 1)) begin
			div  <= 32'h0000_0000;
			tick <= 1'b1;
		end else begin
			div  <= div + 32'h0000_0001;
			tick <= 1'b0;
		end
	end

	// --------------------------------------------------------------------
	// Step interval
	// --------------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tcnt     <= 8'h00;
			step_due <= 1'b0;
		end else if (tick && tcnt == 8'(TICKS_PER_STEP - 1)) begin
			tcnt     <= 8'h00;
			step_due <= 1'b1;
		end else begin
			tcnt     <= tick ? tcnt + 8'h01 : tcnt;
			step_due <= 1'b0;
		end
	end
endmodule : sgr_tick

// file: sgr_top.sv
// Gain step sequencing, output mode control and AHB-Lite registers.
// Operation
// - The speaker target step comes only from the main volume setting relative to the reference.
// - Separate rising and falling trip steps give hysteresis so the step never toggles.
// - The applied gain moves one step toward the target every 4 ticks of the 60 Hz clock.
// - Line gain comes from main volume minus offset, 16 dB below speaker gain at zero offset.
// - Line gain is capped by the ceiling control setting.
// - A high mode input disables the speaker outputs, a low one enables them.
// - Line outputs stay active in both modes.
// - The headphone shutdown drive is always the inverse of the mode input.
// - With fade low, power-up or shutdown release ramps gain up from mute step by step.
// - With fade low, asserting shutdown ramps gain down to mute at the normal pace.
// - With fade high, power-up or shutdown release reaches the target in under 1 ms.
// - With fade high, asserting shutdown mutes within 1 ms.
`timescale 1ns/1ps
`include "sgr_cfg.svh"
module sgr_top #(
	parameter int TICK_CYCLES = `SGR_TICK_CYCLES
) (
	input  wire logic                hclk,
	input  wire logic                hresetn,
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic                     hreadyout,
	output logic [31:0]              hrdata,
	output logic                     hresp,
	input  wire logic                mode,
	input  wire logic                fade_sel,
	input  wire logic                shutdown_n,
	input  wire sgr_pkg::sgr_step_t  vol_step_rise,
	input  wire sgr_pkg::sgr_step_t  vol_step_fall,
	input  wire sgr_pkg::sgr_step_t  line_gain_offset_ctrl,
	input  wire sgr_pkg::sgr_step_t  line_gain_ceiling_ctrl,
	output sgr_pkg::sgr_step_t       speaker_gain_step,
	output logic                     speaker_mute,
	output logic                     speaker_enable,
	output sgr_pkg::sgr_step_t       line_level_output,
	output sgr_pkg::sgr_step_t       line_gain_effective_level,
	output logic                     line_enable,
	output logic                     hp_shutdown_drive
);
	import sgr_pkg::*;

	logic       tick;
	logic       step_due;
	logic       tick_d;
	sgr_step_t  rise_q;
	sgr_step_t  fall_q;
	sgr_step_t  off_q;
	sgr_step_t  ceil_q;
	sgr_step_t  target;
	sgr_state_t state;
	logic       ctrl_hold;
	logic       dph_wr;
	logic [`SGR_ADDR_W-1:0] dph_addr;

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	function automatic sgr_step_t step_toward(sgr_step_t cur, sgr_step_t tgt);
		if (cur < tgt)
			return 5'(cur + 5'h01);
		else if (cur > tgt)
			return 5'(cur - 5'h01);
		return cur;
	endfunction : step_toward

	function automatic sgr_step_t sat_sub(sgr_step_t a, sgr_step_t b);
		return (a > b) ? 5'(a - b) : `SGR_STEP_MIN;
	endfunction : sat_sub

	sgr_tick #(
		.TICK_CYCLES    (TICK_CYCLES),
		.TICKS_PER_STEP (`SGR_TICKS_PER_STEP)
	) u_tick (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.tick     (tick),
		.step_due (step_due)
	);

	// ------------------------------------------------------------------------
	// Resampling of the quantized control settings
	// ------------------------------------------------------------------------
	// The quantizer may change at any time; sampling only on the slow tick keeps
	// the compare stable for a whole period.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rise_q <= `SGR_STEP_MIN;
			fall_q <= `SGR_STEP_MIN;
			off_q  <= `SGR_STEP_MIN;
			ceil_q <= `SGR_STEP_MAX;
			tick_d <= 1'b0;
		end else begin
			tick_d <= tick;
			if (tick) begin
				rise_q <= vol_step_rise;
				fall_q <= vol_step_fall;
				off_q  <= line_gain_offset_ctrl;
				ceil_q <= line_gain_ceiling_ctrl;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Target with hysteresis
	// ------------------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			target <= `SGR_STEP_MIN;
		end else if (tick_d) begin
			if (rise_q > target)
				target <= rise_q;
			else if (fall_q < target)
				target <= fall_q;
		end
	end

	// The 16 dB gap lives in the line gain table: equal indices sit 16 dB apart.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			line_gain_effective_level <= `SGR_STEP_MIN;
		end else if (sat_sub(target, off_q) > ceil_q) begin
			line_gain_effective_level <= ceil_q;
		end else begin
			line_gain_effective_level <= sat_sub(target, off_q);
		end
	end

	// ------------------------------------------------------------------------
	// Gain sequencer
	// ------------------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state             <= ST_OFF;
			speaker_mute      <= 1'b1;
			speaker_gain_step <= `SGR_STEP_MIN;
			line_level_output <= `SGR_STEP_MIN;
		end else begin
			case (state)
			ST_OFF: begin
				if (shutdown_n) begin
					state        <= ST_ACTIVE;
					speaker_mute <= 1'b0;
					if (fade_sel) begin
						speaker_gain_step <= target;
						line_level_output <= line_gain_effective_level;
					end else begin
						speaker_gain_step <= `SGR_STEP_MIN;
						line_level_output <= `SGR_STEP_MIN;
					end
				end
			end
			ST_ACTIVE: begin
				if (!shutdown_n && fade_sel) begin
					state        <= ST_OFF;
					speaker_mute <= 1'b1;
				end else if (!shutdown_n) begin
					state <= ST_FADE_OUT;
				end else if (step_due && !ctrl_hold) begin
					speaker_gain_step <= step_toward(speaker_gain_step, target);
					line_level_output <= step_toward(line_level_output,
						line_gain_effective_level);
				end
			end
			ST_FADE_OUT: begin
				if (shutdown_n) begin
					state <= ST_ACTIVE;
				end else if (fade_sel) begin
					state        <= ST_OFF;
					speaker_mute <= 1'b1;
				end else if (step_due) begin
					if (speaker_gain_step == `SGR_STEP_MIN) begin
						state        <= ST_OFF;
						speaker_mute <= 1'b1;
					end else begin
						speaker_gain_step <= 5'(speaker_gain_step - 5'h01);
					end
					line_level_output <= sat_sub(line_level_output, 5'h01);
				end
			end
			default: state <= ST_OFF;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Output mode
	// ------------------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			speaker_enable    <= 1'b0;
			hp_shutdown_drive <= 1'b1;
			line_enable       <= 1'b0;
		end else begin
			speaker_enable    <= !mode;
			hp_shutdown_drive <= !mode;
			line_enable       <= 1'b1;
		end
	end

	// ------------------------------------------------------------------------
	// AHB-Lite slave, zero wait states
	// ------------------------------------------------------------------------
	function automatic logic [31:0] read_mux(logic [`SGR_ADDR_W-1:0] a);
		logic [31:0] d;
		d = 32'h0000_0000;
		if (a == `SGR_ADDR_CTRL) begin
			d[`SGR_CTRL_HOLD_BIT] = ctrl_hold;
		end else if (a == `SGR_ADDR_STATUS) begin
			d[`SGR_STAT_STEP_LSB +: 5] = speaker_gain_step;
			d[`SGR_STAT_LINE_LSB +: 5] = line_level_output;
			d[`SGR_STAT_MUTE_BIT]      = speaker_mute;
			d[`SGR_STAT_FSM_LSB +: 2]  = state;
		end else if (a == `SGR_ADDR_TARGET) begin
			d[`SGR_TGT_SPK_LSB +: 5]  = target;
			d[`SGR_TGT_LINE_LSB +: 5] = line_gain_effective_level;
		end else if (a == `SGR_ADDR_PINS) begin
			d[`SGR_PIN_MODE_BIT] = mode;
			d[`SGR_PIN_FADE_BIT] = fade_sel;
			d[`SGR_PIN_SDN_BIT]  = shutdown_n;
		end
		return d;
	endfunction : read_mux

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dph_wr    <= 1'b0;
			dph_addr  <= '0;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else if (hsel && hready && htrans[1]) begin
			dph_wr   <= hwrite;
			dph_addr <= haddr[`SGR_ADDR_W-1:0];
			hrdata   <= hwrite ? 32'h0000_0000 : read_mux(haddr[`SGR_ADDR_W-1:0]);
		end else if (hready) begin
			dph_wr <= 1'b0;
		end
	end

	// Only the control register is writable; other addresses ignore writes.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_hold <= 1'(`SGR_CTRL_RESET);
		end else if (dph_wr && dph_addr == `SGR_ADDR_CTRL) begin
			ctrl_hold <= hwdata[`SGR_CTRL_HOLD_BIT];
		end
	end

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// The flops still sit in reset at the edge where the bench lifts hresetn, so every
	// one-cycle follow check starts only from an edge that already saw reset released.
	hp_drive_a: assert property (hresetn |=> hp_shutdown_drive == !$past(mode))
		else $error("Headphone drive is not the inverse of mode.");
	spk_enable_a: assert property (hresetn |=> speaker_enable == !$past(mode))
		else $error("Speaker enable does not follow mode.");
	line_active_a: assert property (hresetn |=> line_enable)
		else $error("Line outputs not active.");
	step_pace_a: assert property ((state == ST_ACTIVE && $past(state) == ST_ACTIVE
		&& $changed(speaker_gain_step)) |-> $past(step_due))
		else $error("Gain step changed off the step pace.");
	one_step_a: assert property (($changed(speaker_gain_step) && $past(state) != ST_OFF)
		|-> (speaker_gain_step == 5'($past(speaker_gain_step) + 5'h01)
		|| speaker_gain_step == 5'($past(speaker_gain_step) - 5'h01)))
		else $error("Gain moved by more than one step.");
	hyst_hold_a: assert property ((tick_d && rise_q <= target && fall_q >= target)
		|=> $stable(target))
		else $error("Target moved inside the hysteresis band.");
	target_src_a: assert property ($changed(target) |-> $past(tick_d))
		else $error("Target changed without a resampling tick.");
	line_cap_a: assert property (hresetn |=> line_gain_effective_level <= $past(ceil_q))
		else $error("Line gain above the ceiling.");
	line_diff_a: assert property (hresetn |=> line_gain_effective_level <= $past(target))
		else $error("Line gain above the volume step.");
	fast_mute_a: assert property ((state == ST_ACTIVE && !shutdown_n && fade_sel)
		|=> speaker_mute)
		else $error("Fast mute did not happen.");
	fast_up_a: assert property ((state == ST_OFF && shutdown_n && fade_sel)
		|=> !speaker_mute && speaker_gain_step == $past(target))
		else $error("Fast start did not reach the target.");
	ramp_start_a: assert property ((state == ST_OFF && shutdown_n && !fade_sel)
		|=> !speaker_mute && speaker_gain_step == `SGR_STEP_MIN)
		else $error("Fade-in did not start at the lowest step.");
	fade_down_a: assert property ((state == ST_FADE_OUT && !shutdown_n && !fade_sel
		&& step_due && speaker_gain_step != `SGR_STEP_MIN)
		|=> speaker_gain_step == 5'($past(speaker_gain_step) - 5'h01))
		else $error("Fade-out did not step down.");

	ramp_up_c: cover property (speaker_gain_step == `SGR_STEP_MAX && state == ST_ACTIVE);
	fade_mute_c: cover property ($past(state) == ST_FADE_OUT && state == ST_OFF);
	fast_mute_c: cover property ($past(state) == ST_ACTIVE && state == ST_OFF);
	hyst_band_c: cover property (tick_d && rise_q < fall_q);
endmodule : sgr_top

// file: sgr_host_model.sv
// Host side model: volume DAC with its quantizer, jack switch and shutdown control.
`timescale 1ns/1ps
module sgr_host_model (
	input  wire logic               hclk,
	input  wire sgr_pkg::sgr_step_t lvl,
	input  wire logic               in_band,
	input  wire sgr_pkg::sgr_step_t off_req,
	input  wire sgr_pkg::sgr_step_t ceil_req,
	input  wire logic               mode_req,
	input  wire logic               fast_req,
	input  wire logic               sdn_req,
	output logic                    mode,
	output logic                    fade_sel,
	output logic                    shutdown_n,
	output sgr_pkg::sgr_step_t      vol_step_rise,
	output sgr_pkg::sgr_step_t      vol_step_fall,
	output sgr_pkg::sgr_step_t      line_gain_offset_ctrl,
	output sgr_pkg::sgr_step_t      line_gain_ceiling_ctrl
);
	import sgr_pkg::*;
	initial begin
		{mode, fade_sel, shutdown_n} = 3'b000;
		{vol_step_rise, vol_step_fall} = 10'h000;
		{line_gain_offset_ctrl, line_gain_ceiling_ctrl} = 10'h000;
	end
	// A level in the hysteresis band sits just under the rising trip, so the raise table
	// still reads one step lower. Codes are 5 bits, so no level can pass full scale.
	always @(posedge hclk) begin
		vol_step_fall <= lvl;
		vol_step_rise <= (in_band && lvl != 5'h00) ? lvl - 5'h01 : lvl;
		line_gain_offset_ctrl <= off_req;
		line_gain_ceiling_ctrl <= ceil_req;
		mode <= mode_req;
		fade_sel <= fast_req;
		shutdown_n <= sdn_req;
	end
endmodule : sgr_host_model

// file: sgr_top_tb.sv
// Self-checking testbench for the stepped gain ramp control block.
`timescale 1ns/1ps
`include "sgr_cfg.svh"
module sgr_top_tb;
	import sgr_pkg::*;
	localparam int TC  = 20;
	localparam int SP  = 4 * TC;
	localparam int MS1 = 1000;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
	logic [1:0]  htrans = 2'b00;
	logic [2:0]  hsize = 3'b010;
	logic        hreadyout, hresp, mode, fade_sel, shutdown_n, in_band = 1'b0;
	logic        mode_req = 1'b0, fast_req = 1'b0, sdn_req = 1'b0;
	logic        speaker_mute, speaker_enable, line_enable, hp_shutdown_drive;
	sgr_step_t   vol_step_rise, vol_step_fall, off_c, ceil_c, lvl = 5'h00;
	sgr_step_t   off_req = 5'h00, ceil_req = 5'h1F, speaker_gain_step, line_level_output;
	sgr_step_t   line_gain_effective_level, prev_step = 5'h00;
	int          bad_count = 0, n_checks = 0, tgt = 0, dir_tgt = 0, gap = 0, t, o, c;
	logic [31:0] lfsr_q = 32'h0000_5aef;
	logic        prev_mute = 1'b1, armed = 1'b0;

	always #2.5 hclk = ~hclk;

	sgr_host_model host_i (.hclk(hclk), .lvl(lvl), .in_band(in_band), .off_req(off_req),
		.ceil_req(ceil_req), .mode_req(mode_req), .fast_req(fast_req), .sdn_req(sdn_req),
		.mode(mode), .fade_sel(fade_sel), .shutdown_n(shutdown_n),
		.vol_step_rise(vol_step_rise), .vol_step_fall(vol_step_fall),
		.line_gain_offset_ctrl(off_c), .line_gain_ceiling_ctrl(ceil_c));

	sgr_top #(.TICK_CYCLES(TC)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.mode(mode), .fade_sel(fade_sel), .shutdown_n(shutdown_n),
		.vol_step_rise(vol_step_rise), .vol_step_fall(vol_step_fall),
		.line_gain_offset_ctrl(off_c), .line_gain_ceiling_ctrl(ceil_c),
		.speaker_gain_step(speaker_gain_step), .speaker_mute(speaker_mute),
		.speaker_enable(speaker_enable), .line_level_output(line_level_output),
		.line_gain_effective_level(line_gain_effective_level),
		.line_enable(line_enable), .hp_shutdown_drive(hp_shutdown_drive));

	// ------------------------------------------------------------------
	// Checking, reporting and the reference model
	// ------------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic report_and_stop();
		if (bad_count == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : report_and_stop

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	function automatic int exp_line(input int tv, input int ov, input int cv);
		int d;
		d = (tv > ov) ? tv - ov : 0;
		return (d < cv) ? d : cv;
	endfunction : exp_line

	// The model keeps the hysteresis target: raise on the rising step, lower on the falling one.
	task automatic host(input int l, input logic b, input logic s, input logic f);
		int r;
		@(posedge hclk);
		lvl <= 5'(l);
		in_band <= b;
		sdn_req <= s;
		fast_req <= f;
		r = (b && l != 0) ? l - 1 : l;
		if (r > tgt) tgt = r;
		else if (l < tgt) tgt = l;
		dir_tgt = s ? tgt : 0;
	endtask : host

	task automatic wait_out(input int s, input logic m, input int bound);
		int n;
		n = 0;
		while (!(speaker_gain_step === 5'(s) && speaker_mute === m) && n < bound) begin
			@(negedge hclk);
			n++;
		end
		if (n >= bound) begin
			chk(32'h0000_0000, 32'h0000_0001);
			report_and_stop();
		end
	endtask : wait_out

	task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {20'h0_0000, a};
		htrans <= 2'b10;
		hwrite <= wr;
		for (n = 0; n < 50; n++) begin
			@(posedge hclk);
			if (hreadyout === 1'b1) break;
		end
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		for (n = n; n < 50; n++) begin
			@(posedge hclk);
			if (hreadyout === 1'b1) break;
		end
		rd = hrdata;
		if (n >= 50) begin
			chk(32'h0000_0000, 32'h0000_0001);
			report_and_stop();
		end
	endtask : ahb

	// With fade low and the speaker unmuted, each applied step change must be one step toward the target, on the step pacing.
	always @(negedge hclk) begin
		gap++;
		if (hresetn && fade_sel === 1'b0 && prev_mute === 1'b0 && speaker_mute === 1'b0
				&& speaker_gain_step !== prev_step) begin
			chk(speaker_gain_step, (prev_step < dir_tgt) ? prev_step + 1 : prev_step - 1);
			if (armed) chk(gap % SP, 32'h0000_0000);
			armed = 1'b1;
			gap = 0;
		end
		if (speaker_mute !== 1'b0 || fade_sel !== 1'b0) armed = 1'b0;
		prev_step = speaker_gain_step;
		prev_mute = speaker_mute;
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (12) @(posedge hclk);
		chk({hreadyout, hresp, speaker_mute, speaker_enable, hp_shutdown_drive}, 5'b10101);
		chk(hrdata, 32'h0000_0000);
		hresetn <= 1'b1;
		ahb(1'b0, `SGR_ADDR_CTRL, 32'h0000_0000);
		chk(rd, `SGR_CTRL_RESET);
		ahb(1'b1, `SGR_ADDR_STATUS, 32'hFFFF_FFFF);
		ahb(1'b0, `SGR_ADDR_STATUS, 32'h0000_0000);
		chk(rd, 32'h0001_0000);
		ahb(1'b0, 12'h010, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		for (int i = 0; i < 3; i++) begin
			@(posedge hclk);
			mode_req <= i[0];
			repeat (3) @(negedge hclk);
			chk({speaker_enable, hp_shutdown_drive, line_enable}, {~i[0], ~i[0], 1'b1});
		end
		for (int it = 0; it < 2; it++) begin
			lfsr_q = lfsr_next(lfsr_next(lfsr_q));
			t = 3 + int'(lfsr_q[2:0]);
			o = int'(lfsr_q[9:8]);
			c = 2 + int'(lfsr_q[12:10]);
			off_req <= 5'(o);
			ceil_req <= 5'(c);
			host(t, 1'b0, 1'b0, 1'b0);
			repeat (3 * TC) @(negedge hclk);
			host(t, 1'b0, 1'b1, 1'b0);
			wait_out(t, 1'b0, (t + 3) * SP);
			repeat (2 * SP) @(negedge hclk);
			chk(line_gain_effective_level, exp_line(t, o, c));
			chk(line_level_output, exp_line(t, o, c));
			ahb(1'b0, `SGR_ADDR_TARGET, 32'h0000_0000);
			chk(rd[12:0], {5'(exp_line(t, o, c)), 3'b000, 5'(t)});
			ahb(1'b0, `SGR_ADDR_STATUS, 32'h0000_0000);
			chk(rd, 32'h0010_0000 | (exp_line(t, o, c) << 8) | t);
			@(posedge hclk);
			off_req <= 5'h00;
			ceil_req <= 5'h1F;
			repeat (2 * SP) @(negedge hclk);
			chk(speaker_gain_step, t);
			chk(line_gain_effective_level, t);
			host(t + 1, 1'b1, 1'b1, 1'b0);
			repeat (2 * SP) @(negedge hclk);
			chk(speaker_gain_step, t);
			host(t - 1, 1'b1, 1'b1, 1'b0);
			wait_out(t - 1, 1'b0, 3 * SP);
			host(t, 1'b1, 1'b1, 1'b0);
			repeat (2 * SP) @(negedge hclk);
			chk(speaker_gain_step, t - 1);
			ahb(1'b1, `SGR_ADDR_CTRL, 32'h0000_0001);
			host(t + 4, 1'b0, 1'b1, 1'b0);
			repeat (3 * SP) @(negedge hclk);
			chk(speaker_gain_step, t - 1);
			ahb(1'b1, `SGR_ADDR_CTRL, 32'h0000_0000);
			wait_out(t + 4, 1'b0, 8 * SP);
			host(t + 4, 1'b0, 1'b0, 1'b0);
			wait_out(0, 1'b1, (t + 8) * SP);
			chk(speaker_mute, 1'b1);
		end
		host(9, 1'b0, 1'b0, 1'b1);
		repeat (3 * TC) @(negedge hclk);
		host(9, 1'b0, 1'b1, 1'b1);
		wait_out(9, 1'b0, MS1);
		chk(speaker_gain_step, 5'h09);
		host(9, 1'b0, 1'b0, 1'b1);
		wait_out(9, 1'b1, MS1);
		chk(speaker_mute, 1'b1);
		ahb(1'b0, `SGR_ADDR_PINS, 32'h0000_0000);
		chk(rd, 32'h0000_0002);
		report_and_stop();
	end
endmodule : sgr_top_tb
